// *** rtl/cpu_stack_ptr.sv ***
// CPU return stack, interrupt shadow registers and two indirect pointers.
// Assumes a sequencer on clk_i, file registers read combinationally and
// program memory read one edge after its address, Wishbone master on clk_i.
// Notes on behaviour
// - Sixteen-entry, fifteen-bit return stack, separate from data memory.
// - Overflow sets the overflow flag, underflow the underflow flag, in power control.
// - With fault reset enabled, either stack fault also pulses a software reset.
// - Interrupt entry copies core context and pointers into shadow registers.
// - Interrupt return copies shadow contents back automatically.
// - Two independent sixteen-bit indirect pointers.
// - Each pointer reaches all file registers and program memory.
// - Indirect access to program memory takes one extra cycle.
// - Linear window maps contiguous addresses onto 80-byte bank portions.
// - Pointer instructions belong to the 49-instruction set decoded by the core.
// - High byte bit 7 selects program memory; reads return low eight bits.
// - Indirect writes aimed at program memory have no effect.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cpu_core_params.svh"
module cpu_stack_ptr (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Wishbone slave
   input  wire logic                      cyc_i,
   input  wire logic                      stb_i,
   input  wire logic                      we_i,
   input  wire logic [7:0]                adr_i,
   input  wire logic [3:0]                sel_i,
   input  wire logic [31:0]               dat_i,
   output logic      [31:0]               dat_o,
   output logic                           ack_o,
   // Sequencer: stack
   input  wire logic                      push_i,
   input  wire logic [14:0]               push_pc_i,
   input  wire logic                      pop_i,
   output logic      [14:0]               pop_pc_o,
   output logic                           soft_rst_o,
   // Sequencer: interrupt context
   input  wire logic                      irq_entry_i,
   input  wire logic                      irq_return_i,
   input  wire cpu_core_pkg::core_ctx_type ctx_i,
   output cpu_core_pkg::core_ctx_type     ctx_o,
   output logic                           restore_o,
   // Sequencer: pointers and indirect port
   input  wire cpu_core_pkg::ptr_op_type  ptr_op_i,
   input  wire cpu_core_pkg::ind_req_type ind_req_i,
   output logic                           ind_busy_o,
   output logic                           ind_done_o,
   output logic      [7:0]                ind_rdata_o,
   output logic      [15:0]               ptr0_o,
   output logic      [15:0]               ptr1_o,
   // Data memory
   output logic      [11:0]               dmem_addr_o,
   output logic                           dmem_we_o,
   output logic      [7:0]                dmem_wdata_o,
   input  wire logic [7:0]                dmem_rdata_i,
   // Program memory
   output logic      [14:0]               pmem_addr_o,
   input  wire logic [13:0]               pmem_rdata_i
);
   localparam logic [4:0]  FULL      = 5'(`STK_DEPTH);
   localparam logic [15:0] LIN_SPAN  = 16'(`GPR_BYTES * `LIN_BANKS);
   localparam logic [11:0] GPR_BYTES = 12'(`GPR_BYTES);

   cpu_core_pkg::state_type s_q;
   cpu_core_pkg::state_type s_d;
   logic [14:0] stk_rdata;
   logic        stk_we;
   logic        take;
   logic [15:0] ea;

   // Linear view: consecutive addresses run through the GPR part of each bank
   function automatic logic [11:0] map_data(input logic [15:0] a);
      logic [11:0] off;
      logic [11:0] bank;
      logic [11:0] rem;
      off  = a[11:0];
      bank = off / GPR_BYTES;
      rem  = off - bank * GPR_BYTES;
      if (a >= `LIN_BASE && a < `LIN_BASE + LIN_SPAN) begin
         map_data = {bank[4:0], `GPR_FIRST + rem[6:0]};
      end else begin
         map_data = a[11:0];
      end
   endfunction

   always_comb begin
      logic [15:0] p;
      logic [15:0] kx;
      logic        fault;
      p     = ind_req_i.sel ? s_q.ptr1 : s_q.ptr0;
      kx    = {{10{ind_req_i.k[5]}}, ind_req_i.k};
      fault = 1'b0;
      s_d   = s_q;
      s_d.done     = 1'b0;
      s_d.dwe      = 1'b0;
      s_d.restore  = 1'b0;
      s_d.soft_rst = 1'b0;
      s_d.ack      = 1'b0;
      take   = ind_req_i.valid && s_q.st == cpu_core_pkg::ST_IDLE;
      stk_we = 1'b0;
      unique case (ind_req_i.mode)
         cpu_core_pkg::MODE_OFFSET:  ea = p + kx;
         cpu_core_pkg::MODE_PREINC:  ea = p + 16'h0001;
         cpu_core_pkg::MODE_PREDEC:  ea = p - 16'h0001;
         cpu_core_pkg::MODE_POSTINC: ea = p;
         cpu_core_pkg::MODE_POSTDEC: ea = p;
         default:                    ea = p;
      endcase

      // Wishbone: one wait state, then ack for one cycle
      if (cyc_i && stb_i && !s_q.ack) begin
         s_d.ack    = 1'b1;
         s_d.wb_dat = 32'h0000_0000;
         unique case (adr_i)
            `REG_CTRL: begin
               s_d.wb_dat[`CTRL_FAULT_EN] = s_q.fault_en;
               if (we_i && sel_i[0]) begin
                  s_d.fault_en = dat_i[`CTRL_FAULT_EN];
               end
            end
            `REG_POWER_CONTROL_REG: begin
               s_d.wb_dat[`POWER_CONTROL_REG_OVF] = s_q.ovf;
               s_d.wb_dat[`POWER_CONTROL_REG_UNF] = s_q.unf;
               // Writing zero clears a flag; a fault in the same cycle wins below
               if (we_i && sel_i[0]) begin
                  s_d.ovf = s_q.ovf & dat_i[`POWER_CONTROL_REG_OVF];
                  s_d.unf = s_q.unf & dat_i[`POWER_CONTROL_REG_UNF];
               end
            end
            `REG_PTR0: begin
               s_d.wb_dat[15:0] = s_q.ptr0;
               if (we_i && sel_i[0]) s_d.ptr0[7:0] = dat_i[7:0];
               if (we_i && sel_i[1]) s_d.ptr0[15:8] = dat_i[15:8];
            end
            `REG_PTR1: begin
               s_d.wb_dat[15:0] = s_q.ptr1;
               if (we_i && sel_i[0]) s_d.ptr1[7:0] = dat_i[7:0];
               if (we_i && sel_i[1]) s_d.ptr1[15:8] = dat_i[15:8];
            end
            `REG_STACK: s_d.wb_dat[4:0] = s_q.count;
            default:    s_d.wb_dat = 32'h0000_0000;
         endcase
      end

      // Pointer instructions from the decoder: load or add literal
      if (ptr_op_i.valid) begin
         if (ptr_op_i.sel) begin
            s_d.ptr1 = ptr_op_i.add ? s_q.ptr1 + ptr_op_i.value : ptr_op_i.value;
         end else begin
            s_d.ptr0 = ptr_op_i.add ? s_q.ptr0 + ptr_op_i.value : ptr_op_i.value;
         end
      end

      // Indirect access
      unique case (s_q.st)
         cpu_core_pkg::ST_IDLE: begin
            if (take) begin
               if (ind_req_i.mode != cpu_core_pkg::MODE_OFFSET) begin
                  if (ind_req_i.sel) s_d.ptr1 = (ind_req_i.mode == cpu_core_pkg::MODE_PREINC ||
                     ind_req_i.mode == cpu_core_pkg::MODE_POSTINC) ? p + 16'h0001 : p - 16'h0001;
                  else s_d.ptr0 = (ind_req_i.mode == cpu_core_pkg::MODE_PREINC ||
                     ind_req_i.mode == cpu_core_pkg::MODE_POSTINC) ? p + 16'h0001 : p - 16'h0001;
               end
               if (ea[`PTR_PROG_BIT]) begin
                  s_d.paddr = ea[14:0];
                  s_d.st    = cpu_core_pkg::ST_PROG;
               end else begin
                  s_d.daddr  = map_data(ea);
                  s_d.dwe    = ind_req_i.we;
                  s_d.dwdata = ind_req_i.wdata;
                  s_d.st     = cpu_core_pkg::ST_DATA;
               end
            end
         end
         cpu_core_pkg::ST_DATA: begin
            s_d.rdata = dmem_rdata_i;
            s_d.done  = 1'b1;
            s_d.st    = cpu_core_pkg::ST_IDLE;
         end
         cpu_core_pkg::ST_PROG: begin
            // Program words come from a synchronous read, so the word is not here yet
            s_d.st = cpu_core_pkg::ST_FETCH;
         end
         cpu_core_pkg::ST_FETCH: begin
            // Program memory has no write path from here; a write just completes
            s_d.rdata = pmem_rdata_i[7:0];
            s_d.done  = 1'b1;
            s_d.st    = cpu_core_pkg::ST_IDLE;
         end
      endcase

      // Return stack
      if (push_i) begin
         if (s_q.count == FULL) begin
            s_d.ovf = 1'b1;
            fault   = 1'b1;
         end else begin
            stk_we    = 1'b1;
            s_d.count = s_q.count + 5'h01;
         end
      end else if (pop_i) begin
         if (s_q.count == 5'h00) begin
            s_d.unf = 1'b1;
            fault   = 1'b1;
         end else begin
            s_d.count = s_q.count - 5'h01;
         end
      end

      // Interrupt context
      if (irq_entry_i) begin
         s_d.sh_ctx  = ctx_i;
         s_d.sh_ptr0 = s_q.ptr0;
         s_d.sh_ptr1 = s_q.ptr1;
      end else if (irq_return_i) begin
         s_d.restore = 1'b1;
         s_d.ptr0    = s_q.sh_ptr0;
         s_d.ptr1    = s_q.sh_ptr1;
      end

      // Fault reset clears the stack and pointers but keeps the flags as the cause
      if (fault && s_q.fault_en) begin
         s_d.soft_rst = 1'b1;
         s_d.count    = 5'h00;
         s_d.ptr0     = 16'h0000;
         s_d.ptr1     = 16'h0000;
         s_d.st       = cpu_core_pkg::ST_IDLE;
         s_d.dwe      = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.st <= cpu_core_pkg::ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   return_stack_mem #(
      .WIDTH (`STK_WIDTH),
      .DEPTH (`STK_DEPTH),
      .AW    (4)
   ) u_stack (
      .clk_i   (clk_i),
      .we_i    (stk_we),
      .waddr_i (s_q.count[3:0]),
      .wdata_i (push_pc_i),
      .raddr_i (4'(s_q.count - 5'h01)),
      .rdata_o (stk_rdata)
   );

   assign dat_o        = s_q.wb_dat;
   assign ack_o        = s_q.ack;
   assign pop_pc_o     = stk_rdata;
   assign soft_rst_o   = s_q.soft_rst;
   assign ctx_o        = s_q.sh_ctx;
   assign restore_o    = s_q.restore;
   assign ind_busy_o   = s_q.st != cpu_core_pkg::ST_IDLE;
   assign ind_done_o   = s_q.done;
   assign ind_rdata_o  = s_q.rdata;
   assign ptr0_o       = s_q.ptr0;
   assign ptr1_o       = s_q.ptr1;
   assign dmem_addr_o  = s_q.daddr;
   assign dmem_we_o    = s_q.dwe;
   assign dmem_wdata_o = s_q.dwdata;
   assign pmem_addr_o  = s_q.paddr;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence take_prog_s;
      take && ea[`PTR_PROG_BIT] && !soft_rst_o;
   endsequence
   sequence take_data_s;
      take && !ea[`PTR_PROG_BIT];
   endsequence
   // Program access: two busy cycles while the synchronous word read settles, then done
   sequence prog_wait_s;
      ind_busy_o && !ind_done_o ##1 ind_busy_o && !ind_done_o ##1 ind_done_o;
   endsequence
   sequence pop_only_s;
      pop_i && !push_i;
   endsequence

   ovf_flag_a: assert property (push_i && s_q.count == FULL |=> s_q.ovf)
      else $error("overflow flag not set");
   unf_flag_a: assert property (pop_i && !push_i && s_q.count == 5'h00 |=> s_q.unf)
      else $error("underflow flag not set");
   fault_reset_a: assert property (push_i && s_q.count == FULL && s_q.fault_en |=> soft_rst_o && s_q.count == 5'h00)
      else $error("fault reset missing");
   reset_cause_a: assert property (soft_rst_o |-> $past(s_q.fault_en) && (s_q.ovf || s_q.unf))
      else $error("software reset without enabled fault");
   push_count_a: assert property (push_i && s_q.count < FULL |=> s_q.count == $past(s_q.count) + 5'h01)
      else $error("stack pointer did not advance");
   shadow_save_a: assert property (irq_entry_i |=> ctx_o == $past(ctx_i))
      else $error("shadow context wrong");
   shadow_back_a: assert property (irq_return_i && !irq_entry_i && !push_i && !pop_i && !ptr_op_i.valid
      && !ind_req_i.valid |=> restore_o && ptr0_o == $past(s_q.sh_ptr0))
      else $error("pointer not restored");
   prog_extra_a: assert property (take_prog_s |=> !ind_done_o [*2] ##1 ind_done_o)
      else $error("program access timing wrong");
   data_timing_a: assert property (take_data_s |=> !ind_done_o ##1 ind_done_o)
      else $error("data access timing wrong");
   prog_low_byte_a: assert property (s_q.st == cpu_core_pkg::ST_FETCH |=> ind_rdata_o == $past(pmem_rdata_i[7:0]))
      else $error("program read data wrong");
   prog_no_write_a: assert property (take_prog_s |=> !dmem_we_o ##1 !dmem_we_o)
      else $error("write reached data memory");
   linear_gpr_a: assert property (take_data_s ##0 (ea >= `LIN_BASE && ea < `LIN_BASE + LIN_SPAN)
      |=> dmem_addr_o[6:0] >= `GPR_FIRST && dmem_addr_o[6:0] < `GPR_FIRST + 7'(`GPR_BYTES))
      else $error("linear address outside GPR");

   // Stack pointer bounds and fault handling
   pop_count_a: assert property (pop_only_s ##0 (s_q.count != 5'h00)
      |=> s_q.count == $past(s_q.count) - 5'h01)
      else $error("stack pointer did not retreat");
   unf_reset_a: assert property (pop_only_s ##0 (s_q.count == 5'h00 && s_q.fault_en)
      |=> soft_rst_o && ptr0_o == 16'h0000 && !ind_busy_o)
      else $error("underflow reset missing");
   ovf_hold_a: assert property (push_i && s_q.count == FULL && !s_q.fault_en |=> s_q.count == FULL)
      else $error("stack pointer moved on overflow");
   ovf_no_write_a: assert property (push_i && s_q.count == FULL |-> !stk_we)
      else $error("overflowing push was stored");
   depth_bound_a: assert property (s_q.count <= FULL)
      else $error("stack depth beyond sixteen");

   // Indirect port strobes and addresses
   prog_busy_a: assert property (take_prog_s |=> prog_wait_s)
      else $error("program access busy window wrong");
   prog_addr_a: assert property (take_prog_s |=> pmem_addr_o == $past(ea[14:0]))
      else $error("program address wrong");
   data_we_a: assert property (take_data_s |=> dmem_we_o == ($past(ind_req_i.we) && !soft_rst_o))
      else $error("data write strobe wrong");
   done_pulse_a: assert property (ind_done_o |=> !ind_done_o)
      else $error("done longer than one cycle");
   we_pulse_a: assert property (dmem_we_o |=> !dmem_we_o)
      else $error("data write longer than one cycle");

   // Shadow registers and pointer loads
   shadow_ptr_a: assert property (irq_entry_i |=> s_q.sh_ptr0 == $past(s_q.ptr0)
      && s_q.sh_ptr1 == $past(s_q.ptr1))
      else $error("pointers not shadowed");
   restore_pulse_a: assert property (irq_return_i && !irq_entry_i |=> restore_o)
      else $error("restore pulse missing");
   ptr_load_a: assert property (ptr_op_i.valid && !ptr_op_i.sel && !ptr_op_i.add && !ind_req_i.valid
      && !irq_return_i && !push_i && !pop_i |=> ptr0_o == $past(ptr_op_i.value))
      else $error("pointer load lost");
endmodule

// *** rtl/cpu_core_params.svh ***
// Constants of the CPU stack and indirect pointer block.
// Included by the package and the design modules; definitions only.
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH
`define STK_DEPTH      16
`define STK_WIDTH      15
`define STK_CNT_W      5
`define PTR_WIDTH      16
`define PTR_PROG_BIT   15
`define LIN_BASE       16'h2000
`define LIN_BANKS      32
`define GPR_BYTES      80
`define GPR_FIRST      7'h20
`define INSN_COUNT     49
`define REG_CTRL       8'h00
`define REG_POWER_CONTROL_REG       8'h04
`define REG_PTR0       8'h08
`define REG_PTR1       8'h0C
`define REG_STACK      8'h10
`define CTRL_FAULT_EN  0
`define POWER_CONTROL_REG_OVF       7
`define POWER_CONTROL_REG_UNF       6
`endif

// *** rtl/cpu_core_pkg.sv ***
// Types shared by the stack and indirect pointer block.
// Assumes cpu_core_params.svh is on the include path.
`include "cpu_core_params.svh"
package cpu_core_pkg;
   typedef enum logic [2:0] {
      MODE_OFFSET  = 3'h0,
      MODE_PREINC  = 3'h1,
      MODE_PREDEC  = 3'h2,
      MODE_POSTINC = 3'h3,
      MODE_POSTDEC = 3'h4
   } ptr_mode_type;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_DATA  = 4'b0010,
      ST_PROG  = 4'b0100,
      ST_FETCH = 4'b1000
   } acc_state_type;
   typedef struct packed {
      logic         valid;
      logic         sel;
      logic         we;
      ptr_mode_type mode;
      logic [5:0]   k;
      logic [7:0]   wdata;
   } ind_req_type;
   typedef struct packed {
      logic        valid;
      logic        sel;
      logic        add;
      logic [15:0] value;
   } ptr_op_type;
   typedef struct packed {
      logic [4:0] status;
      logic [7:0] work;
      logic [4:0] bank;
      logic [6:0] pc_latch;
   } core_ctx_type;
   typedef struct packed {
      logic [4:0]    count;
      logic          ovf;
      logic          unf;
      logic          fault_en;
      logic          soft_rst;
      logic [15:0]   ptr0;
      logic [15:0]   ptr1;
      core_ctx_type  sh_ctx;
      logic [15:0]   sh_ptr0;
      logic [15:0]   sh_ptr1;
      logic          restore;
      acc_state_type st;
      logic          done;
      logic [7:0]    rdata;
      logic [11:0]   daddr;
      logic          dwe;
      logic [7:0]    dwdata;
      logic [14:0]   paddr;
      logic          ack;
      logic [31:0]   wb_dat;
   } state_type;
endpackage

// *** rtl/return_stack_mem.sv ***
// Return stack storage: synchronous write, registered read.
// Assumes one clock; read data follow the read address one edge later.
`timescale 1ns/1ps
`include "cpu_core_params.svh"
module return_stack_mem #(
   parameter int WIDTH = `STK_WIDTH,
   parameter int DEPTH = `STK_DEPTH,
   parameter int AW    = 4
) (
   // Clock
   input  wire logic             clk_i,
   // Write port
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   // Read port
   input  wire logic [AW-1:0]    raddr_i,
   output logic      [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule

// *** verif/mem_model.sv ***
// Far-side model of the pointer block: data array and program words computed from the address.
// Assumes one clock; data reads combinational, program reads one edge late.
`timescale 1ns/1ps
module mem_model (
   // Clock
   input  wire logic        clk_i,
   // Data memory
   input  wire logic [11:0] dmem_addr_i,
   input  wire logic        dmem_we_i,
   input  wire logic [7:0]  dmem_wdata_i,
   output logic      [7:0]  dmem_rdata_o,
   // Program memory
   input  wire logic [14:0] pmem_addr_i,
   output logic      [13:0] pmem_rdata_o
);
   logic [7:0] mem_q [0:4095];
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem_q[i] = i[7:0] ^ 8'h5A;
      end
      pmem_rdata_o = 14'h0000;
   end
   assign dmem_rdata_o = mem_q[dmem_addr_i];
   always @(posedge clk_i) begin
      if (dmem_we_i) begin
         mem_q[dmem_addr_i] <= dmem_wdata_i;
      end
      // Read only: there is no path by which a pointer write reaches program words
      pmem_rdata_o <= pmem_addr_i[13:0] ^ 14'h1B3C;
   end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench of the stack, shadow and indirect pointer block.
// Assumes the package is compiled first; mem_model stands for the memories.
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic push_i = 1'b0, pop_i = 1'b0, soft_rst_o, restore_o;
   logic [14:0] push_pc_i = 15'h0, pop_pc_o, pmem_addr_o;
   logic irq_entry_i = 1'b0, irq_return_i = 1'b0;
   cpu_core_pkg::core_ctx_type ctx_i = '0, ctx_o;
   cpu_core_pkg::ptr_op_type ptr_op_i = '0;
   cpu_core_pkg::ind_req_type ind_req_i = '0;
   logic ind_busy_o, ind_done_o, dmem_we_o;
   logic [7:0] ind_rdata_o, dmem_wdata_o, dmem_rdata_i;
   logic [15:0] ptr0_o, ptr1_o;
   logic [11:0] dmem_addr_o;
   logic [13:0] pmem_rdata_i;
   int bad_count = 0;
   int n_tests = 0;

   always #10 clk_i = ~clk_i;

   cpu_stack_ptr u_cpu_stack_ptr (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .push_i, .push_pc_i, .pop_i, .pop_pc_o, .soft_rst_o, .irq_entry_i,
      .irq_return_i, .ctx_i, .ctx_o, .restore_o, .ptr_op_i, .ind_req_i, .ind_busy_o, .ind_done_o,
      .ind_rdata_o, .ptr0_o, .ptr1_o, .dmem_addr_o, .dmem_we_o, .dmem_wdata_o, .dmem_rdata_i,
      .pmem_addr_o, .pmem_rdata_i);
   mem_model u_mem_model (.clk_i(clk_i), .dmem_addr_i(dmem_addr_o), .dmem_we_i(dmem_we_o),
      .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i), .pmem_addr_i(pmem_addr_o),
      .pmem_rdata_o(pmem_rdata_i));

   function automatic logic [7:0] dpat(input logic [11:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   // Linear window folds 80-byte runs onto the GPR part of each bank
   function automatic logic [11:0] amap(input logic [15:0] ea);
      logic [15:0] off;
      off = ea - 16'h2000;
      if (ea >= 16'h2000 && ea <= 16'h29FF) begin
         return 12'((off / 80) * 128 + 32 + off % 80);
      end
      return ea[11:0];
   endfunction

   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      if (n >= 16) bad_count++;
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hF, q);
      chk(nm, q, exp);
   endtask
   task automatic pset(input logic s, input logic [15:0] v);
      @(posedge clk_i);
      ptr_op_i <= '{1'b1, s, 1'b0, v};
      @(posedge clk_i);
      ptr_op_i.valid <= 1'b0;
   endtask
   task automatic ind(input logic s, w, input cpu_core_pkg::ptr_mode_type m, input logic [5:0] k,
                      input logic [7:0] wd, output logic [7:0] q, output int lat);
      @(posedge clk_i);
      ind_req_i <= '{1'b1, s, w, m, k, wd};
      @(posedge clk_i);
      ind_req_i.valid <= 1'b0;
      lat = 0;
      do begin
         @(posedge clk_i);
         lat++;
         if (lat == 1) chk("busy after take", ind_busy_o, 32'h1);
      end while (ind_done_o !== 1'b1 && lat < 8);
      q = ind_rdata_o;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      final_report();
   end

   initial begin
      logic [31:0] q;
      logic [14:0] v;
      logic [14:0] stk [0:15];
      logic [15:0] p, ea;
      logic [5:0] k;
      logic [7:0] r;
      int lat, n;
      cpu_core_pkg::core_ctx_type cx;
      q = $urandom(17);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 24; a += 4) begin
         rdchk("reg after reset", a[7:0], 32'h0);
      end
      p = 16'($urandom);
      wb(1'b1, 8'h08, {16'h0, p}, 4'hF, q);
      wb(1'b1, 8'h0C, {16'h0, ~p}, 4'hF, q);
      rdchk("ptr1 reg", 8'h0C, {16'h0, ~p});
      chk("ptr0 out", ptr0_o, p);
      wb(1'b1, 8'h08, 32'h0000FFFF, 4'h1, q);
      rdchk("ptr0 low byte", 8'h08, {16'h0, p[15:8], 8'hFF});
      // Seventeen back-to-back pushes, the last one overflows
      for (int i = 0; i < 17; i++) begin
         v = 15'($urandom);
         if (i < 16) stk[i] = v;
         @(posedge clk_i);
         push_i <= 1'b1;
         push_pc_i <= v;
      end
      @(posedge clk_i);
      push_i <= 1'b0;
      rdchk("depth full", 8'h10, 32'd16);
      rdchk("overflow flag", 8'h04, 32'h80);
      wb(1'b1, 8'h04, 32'h0, 4'hF, q);
      @(posedge clk_i);
      pop_i <= 1'b1;
      for (int i = 1; i <= 17; i++) begin
         @(posedge clk_i);
         if (i > 1) chk("pop order", pop_pc_o, stk[17 - i]);
         if (i == 17) pop_i <= 1'b0;
      end
      rdchk("depth empty", 8'h10, 32'h0);
      rdchk("underflow flag", 8'h04, 32'h40);
      wb(1'b1, 8'h04, 32'h0, 4'hF, q);
      pset(1'b0, 16'h1234);
      wb(1'b1, 8'h00, 32'h1, 4'hF, q);
      @(posedge clk_i);
      pop_i <= 1'b1;
      @(posedge clk_i);
      pop_i <= 1'b0;
      n = 0;
      repeat (4) begin
         @(posedge clk_i);
         n += (soft_rst_o === 1'b1);
      end
      chk("fault reset pulse", n, 1);
      chk("pointer cleared", ptr0_o, 16'h0);
      rdchk("flag kept", 8'h04, 32'h40);
      // Overflow with fault reset enabled: sixteen stored, the seventeenth resets
      @(posedge clk_i);
      push_i <= 1'b1;
      repeat (17) @(posedge clk_i);
      push_i <= 1'b0;
      @(posedge clk_i);
      chk("overflow reset pulse", soft_rst_o, 1'b1);
      rdchk("overflow reset flags", 8'h04, 32'hC0);
      rdchk("depth after overflow reset", 8'h10, 32'h0);
      wb(1'b1, 8'h00, 32'h0, 4'hF, q);
      wb(1'b1, 8'h04, 32'h0, 4'hF, q);
      cx = 25'($urandom);
      pset(1'b0, 16'h0AAA);
      pset(1'b1, 16'h0555);
      @(posedge clk_i);
      ctx_i <= cx;
      irq_entry_i <= 1'b1;
      @(posedge clk_i);
      irq_entry_i <= 1'b0;
      pset(1'b0, 16'h0F0F);
      @(posedge clk_i);
      irq_return_i <= 1'b1;
      @(posedge clk_i);
      irq_return_i <= 1'b0;
      @(posedge clk_i);
      chk("restore pulse", restore_o, 1'b1);
      chk("shadow ctx", ctx_o, cx);
      chk("ptr0 restored", ptr0_o, 16'h0AAA);
      chk("ptr1 restored", ptr1_o, 16'h0555);
      for (int i = 0; i < 8; i++) begin
         p = i[0] ? 16'(16'h2000 + $urandom % 2560) : 16'(32 + $urandom % 4000);
         k = 6'($urandom);
         ea = p + {{10{k[5]}}, k};
         pset(i[1], p);
         ind(i[1], 1'b0, cpu_core_pkg::MODE_OFFSET, k, 8'h00, r, lat);
         chk("data read", r, dpat(amap(ea)));
         chk("data latency", lat, 2);
         chk("data addr", dmem_addr_o, amap(ea));
      end
      for (int m = 1; m < 5; m++) begin
         pset(1'b1, 16'h0100);
         ind(1'b1, 1'b0, cpu_core_pkg::ptr_mode_type'(m), 6'h00, 8'h00, r, lat);
         ea = (m == 1) ? 16'h0101 : (m == 2) ? 16'h00FF : 16'h0100;
         chk("mode read", r, dpat(ea[11:0]));
         chk("mode pointer", ptr1_o, (m % 2) ? 16'h0101 : 16'h00FF);
      end
      p = 16'h8000 | 16'(16'h0200 + $urandom % 3000);
      pset(1'b0, p);
      ind(1'b0, 1'b0, cpu_core_pkg::MODE_OFFSET, 6'h00, 8'h00, r, lat);
      chk("prog read", r, p[7:0] ^ 8'h3C);
      chk("prog latency", lat, 3);
      chk("prog addr", pmem_addr_o, p[14:0]);
      ind(1'b0, 1'b1, cpu_core_pkg::MODE_OFFSET, 6'h00, 8'hA5, r, lat);
      chk("prog write latency", lat, 3);
      pset(1'b1, {4'h0, p[11:0]});
      ind(1'b1, 1'b0, cpu_core_pkg::MODE_OFFSET, 6'h00, 8'h00, r, lat);
      chk("no write through", r, dpat(p[11:0]));
      pset(1'b0, 16'h0123);
      ind(1'b0, 1'b1, cpu_core_pkg::MODE_OFFSET, 6'h00, 8'hC3, r, lat);
      chk("write latency", lat, 2);
      chk("write data", dmem_wdata_o, 8'hC3);
      ind(1'b0, 1'b0, cpu_core_pkg::MODE_OFFSET, 6'h00, 8'h00, r, lat);
      chk("write read back", r, 8'hC3);
      final_report();
   end
endmodule
